// file: logic/fixed_reference_pkg.sv
/*
 Package for the fixed reference and temperature indicator control block:
 register offsets, field positions, reset values and settle timing.
 Assumes a single 100 MHz clock and a plain strobe register port.
*/
package fixed_reference_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h2;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int BIT_REF_ENABLE = 7;
	localparam int BIT_REF_READY = 6;
	localparam int BIT_TEMP_ENABLE = 5;
	localparam int BIT_TEMP_RANGE = 4;
	localparam int BIT_GAIN_HI = 1;
	localparam int BIT_GAIN_LO = 0;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// interrupt status bits
	localparam int IRQ_READY_RISE = 0;
	localparam int IRQ_READY_FALL = 1;

	typedef enum logic [1:0]
	{
		GAIN_OFF = 2'h0,
		GAIN_X1 = 2'h1,
		GAIN_X2 = 2'h2,
		GAIN_X4 = 2'h3
	} gain_e;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETTLE_TIME_NS = 25000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: logic/settle_timer.sv
/*
 Settle timer: counts clock cycles while run is high, raises done after
 the programmed count, restarts from zero whenever run drops.
 Assumes run is synchronous to clk.
*/
module settle_timer
	import fixed_reference_pkg::*;
#(
	parameter int COUNT = SETTLE_CYCLES
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic run,
	output logic done
);

	localparam int CW = $clog2(COUNT + 1);

	// refused at elaboration: a zero count would never raise done
	if (COUNT < 1)
		$error("settle_timer: COUNT must be at least one");

	typedef struct packed
	{
		logic [CW-1:0] count;
		logic done;
	} timer_s;

	timer_s state_reg;
	timer_s state_next;

	always_comb
	begin
		state_next = state_reg;
		if (!run)
		begin
			state_next.count = '0;
			state_next.done = 1'b0;
		end
		else if (!state_reg.done)
		begin
			if (state_reg.count == CW'(COUNT - 1))
				state_next.done = 1'b1;
			else
				state_next.count = state_reg.count + CW'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign done = state_reg.done;

endmodule

// file: logic/fixed_reference_temp_control.sv
/*
 Control and status logic for the fixed voltage reference and the die
 temperature indicator sharing it, with ready interrupt bookkeeping.
 Assumes the analog reference, gain amplifier and sensor live outside and
 follow the control outputs; register strobes are one cycle and synchronous.
*/
module fixed_reference_temp_control
	import fixed_reference_pkg::*;
#(
	parameter int SETTLE_COUNT = SETTLE_CYCLES,
	parameter bit STANDARD_VARIANT = 1'b0
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	output logic reference_enable,
	output logic reference_ready,
	output logic temp_sense_enable,
	output logic temp_range_select,
	output logic [1:0] converter_reference_gain,
	output logic irq
);

	// refused at elaboration: the settle timer needs at least one cycle
	if (SETTLE_COUNT < 1)
		$error("fixed_reference_temp_control: SETTLE_COUNT below one");

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic ref_en;
		logic temp_en;
		logic temp_rng;
		logic [1:0] gain;
		logic ready;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic irq;
		logic [7:0] rdata;
	} ctrl_s;

	ctrl_s state_reg;
	ctrl_s state_next;
	logic settled;
	logic ready_now;

	function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
		hit = (addr == target);
	endfunction

	settle_timer #(
		.COUNT(SETTLE_COUNT)
	) u_settle (
		.clk(clk),
		.srst(srst),
		.run(state_reg.ref_en),
		.done(settled)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [7:0] ctrl_word;
		logic [1:0] events;
		ctrl_word = 8'h00;
		events = 2'h0;
		state_next = state_reg;

		if (reg_write && hit(reg_addr, ADDR_CONTROL))
		begin
			state_next.ref_en = reg_wdata[BIT_REF_ENABLE];
			state_next.temp_en = reg_wdata[BIT_TEMP_ENABLE];
			state_next.temp_rng = reg_wdata[BIT_TEMP_RANGE];
			state_next.gain = reg_wdata[BIT_GAIN_HI:BIT_GAIN_LO];
		end
		if (reg_write && hit(reg_addr, ADDR_IRQ_ENABLE))
			state_next.irq_enable = reg_wdata[1:0];

		// ready drops on the same edge as the enable, so no read shows it alone;
		// the old enable term stops a stale done from a quick off-on write pair
		ready_now = settled & state_reg.ref_en & state_next.ref_en;
		if (STANDARD_VARIANT)
			ready_now = 1'b1;
		state_next.ready = ready_now;
		events[IRQ_READY_RISE] = ready_now & ~state_reg.ready;
		events[IRQ_READY_FALL] = ~ready_now & state_reg.ready;

		// a new event beats a clear in the same cycle
		if (reg_write && hit(reg_addr, ADDR_IRQ_CLEAR))
			state_next.irq_status = state_reg.irq_status & ~reg_wdata[1:0];
		state_next.irq_status = state_next.irq_status | events;
		state_next.irq = |(state_next.irq_status & state_next.irq_enable);

		ctrl_word[BIT_REF_ENABLE] = state_reg.ref_en;
		ctrl_word[BIT_REF_READY] = state_reg.ready;
		ctrl_word[BIT_TEMP_ENABLE] = state_reg.temp_en;
		ctrl_word[BIT_TEMP_RANGE] = state_reg.temp_rng;
		ctrl_word[BIT_GAIN_HI:BIT_GAIN_LO] = state_reg.gain;

		// unmapped and write-only addresses read zero
		state_next.rdata = 8'h00;
		if (reg_read)
		begin
			unique case (reg_addr)
				ADDR_CONTROL: state_next.rdata = ctrl_word;
				ADDR_IRQ_STATUS: state_next.rdata = {6'h00, state_reg.irq_status};
				ADDR_IRQ_ENABLE: state_next.rdata = {6'h00, state_reg.irq_enable};
				default: state_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_reg <= '0;
			state_reg.ready <= STANDARD_VARIANT;
		end
		else
			state_reg <= state_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata = state_reg.rdata;
	assign reference_enable = state_reg.ref_en;
	assign reference_ready = state_reg.ready;
	assign temp_sense_enable = state_reg.temp_en;
	assign temp_range_select = state_reg.temp_rng;
	assign converter_reference_gain = state_reg.gain;
	assign irq = state_reg.irq;

	// ------------------------------------------------------------
	// check helper: cycles spent enabled, saturating past the settle
	// ------------------------------------------------------------
	// kept outside the state struct: it only times the assertions below
	localparam int AGE_MAX = SETTLE_COUNT + 1;
	localparam int AW = $clog2(AGE_MAX + 1);
	logic [AW-1:0] en_age_reg;

	always_ff @(posedge clk)
	begin
		if (srst || !reference_enable)
			en_age_reg <= '0;
		else if (en_age_reg != AW'(AGE_MAX))
			en_age_reg <= en_age_reg + AW'(1);
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_enable_write;
		@(posedge clk) disable iff (srst)
		reg_write && reg_addr == ADDR_CONTROL |=> reference_enable == $past(reg_wdata[7]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable bit not written");

	property p_ready_needs_settle;
		@(posedge clk) disable iff (srst)
		!STANDARD_VARIANT && $rose(reference_enable) |-> !reference_ready [*1] ##1 !reference_ready;
	endproperty
	a_ready_needs_settle: assert property (p_ready_needs_settle) else $error("ready too early");

	property p_ready_rises;
		@(posedge clk) disable iff (srst)
		!STANDARD_VARIANT && SETTLE_COUNT <= 900 && $rose(reference_enable)
		|-> ##[1:1000] (reference_ready || !reference_enable);
	endproperty
	a_ready_rises: assert property (p_ready_rises) else $error("ready never rose");

	property p_ready_zero_disabled;
		@(posedge clk) disable iff (srst)
		!STANDARD_VARIANT && !reference_enable |-> !reference_ready;
	endproperty
	a_ready_zero_disabled: assert property (p_ready_zero_disabled) else $error("ready while off");

	property p_ready_standard;
		@(posedge clk) disable iff (srst)
		STANDARD_VARIANT |-> reference_ready;
	endproperty
	a_ready_standard: assert property (p_ready_standard) else $error("standard ready low");

	property p_temp_write;
		@(posedge clk) disable iff (srst)
		reg_write && reg_addr == ADDR_CONTROL
		|=> temp_sense_enable == $past(reg_wdata[5]) && temp_range_select == $past(reg_wdata[4]);
	endproperty
	a_temp_write: assert property (p_temp_write) else $error("temp bits not written");

	property p_gain_write;
		@(posedge clk) disable iff (srst)
		reg_write && reg_addr == ADDR_CONTROL |=> converter_reference_gain == $past(reg_wdata[1:0]);
	endproperty
	a_gain_write: assert property (p_gain_write) else $error("gain not written");

	property p_reserved_zero;
		@(posedge clk) disable iff (srst)
		reg_read && reg_addr == ADDR_CONTROL |=> reg_rdata[3:2] == 2'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

	property p_reset_zero;
		@(posedge clk)
		srst |=> {reference_enable, 1'b0, temp_sense_enable, temp_range_select, 2'b00,
			converter_reference_gain} == CONTROL_RESET
			&& reference_ready == STANDARD_VARIANT
			&& state_reg.irq_status == IRQ_RESET && state_reg.irq_enable == IRQ_RESET
			&& !irq && reg_rdata == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("control not reset");

	property p_restart;
		@(posedge clk) disable iff (srst)
		!STANDARD_VARIANT && $fell(reference_enable) ##1 reference_enable |=> !reference_ready;
	endproperty
	a_restart: assert property (p_restart) else $error("settle did not restart");

	property p_settled_first;
		@(posedge clk) disable iff (srst)
		!STANDARD_VARIANT && reference_ready |-> en_age_reg == AW'(AGE_MAX);
	endproperty
	a_settled_first: assert property (p_settled_first) else $error("ready early");

	property p_ready_due;
		@(posedge clk) disable iff (srst)
		!STANDARD_VARIANT && reference_enable && en_age_reg == AW'(AGE_MAX) |-> reference_ready;
	endproperty
	a_ready_due: assert property (p_ready_due) else $error("ready late");

	property p_idle_rdata;
		@(posedge clk) disable iff (srst)
		!reg_read |=> reg_rdata == 8'h00;
	endproperty
	a_idle_rdata: assert property (p_idle_rdata) else $error("read data not idle");

	property p_ctrl_read;
		@(posedge clk) disable iff (srst)
		reg_read && reg_addr == ADDR_CONTROL
		|=> reg_rdata[BIT_REF_ENABLE] == $past(reference_enable)
			&& reg_rdata[BIT_REF_READY] == $past(reference_ready)
			&& reg_rdata[BIT_GAIN_HI:BIT_GAIN_LO] == $past(converter_reference_gain);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

	property p_read_ready_off;
		@(posedge clk) disable iff (srst)
		!STANDARD_VARIANT && reg_read && reg_addr == ADDR_CONTROL
		|=> !(reg_rdata[BIT_REF_READY] && !reg_rdata[BIT_REF_ENABLE]);
	endproperty
	a_read_ready_off: assert property (p_read_ready_off) else $error("ready read off");

	property p_std_read;
		@(posedge clk) disable iff (srst)
		STANDARD_VARIANT && reg_read && reg_addr == ADDR_CONTROL
		|=> reg_rdata[BIT_REF_READY];
	endproperty
	a_std_read: assert property (p_std_read) else $error("standard read ready low");

	property p_rise_sets;
		@(posedge clk) disable iff (srst)
		$rose(reference_ready) |-> state_reg.irq_status[IRQ_READY_RISE];
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rise not flagged");

	// a fall caused by reset itself is not an event
	property p_fall_sets;
		@(posedge clk) disable iff (srst)
		$fell(reference_ready) && !$past(srst) |-> state_reg.irq_status[IRQ_READY_FALL];
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("fall not flagged");

	property p_control_hold;
		@(posedge clk) disable iff (srst)
		!(reg_write && reg_addr == ADDR_CONTROL)
		|=> $stable(reference_enable) && $stable(temp_sense_enable)
			&& $stable(temp_range_select) && $stable(converter_reference_gain);
	endproperty
	a_control_hold: assert property (p_control_hold) else $error("control moved");

	// ------------------------------------------------------------
	// covers of the main scenarios
	// ------------------------------------------------------------
	c_ready: cover property (@(posedge clk) disable iff (srst) $rose(reference_ready));
	c_irq: cover property (@(posedge clk) disable iff (srst) $rose(irq));
	c_gain4: cover property (@(posedge clk) disable iff (srst) converter_reference_gain == GAIN_X4);
	c_ready_fall: cover property (@(posedge clk) disable iff (srst) $fell(reference_ready));
	c_restart: cover property (@(posedge clk) disable iff (srst)
		$fell(reference_enable) ##1 reference_enable);

endmodule

// file: tb/fixed_reference_temp_control_tb_top.sv
/*
 Bench for the fixed reference control block: register port traffic,
 ready settle timing, interrupt bookkeeping and the standard variant.
 Assumes a short settle count and the register map of the package.
*/
module fixed_reference_temp_control_tb_top
	import fixed_reference_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 8;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic reference_enable, reference_ready, temp_sense_enable, temp_range_select, irq, std_ready;
	logic [1:0] converter_reference_gain;
	logic rd_d = 1'b0;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'ha2fd;
	logic [7:0] d;
	int bad_count = 0;
	int cmp_count = 0;

	always #5 clk = ~clk;

	fixed_reference_temp_control #(.SETTLE_COUNT(SC)) dut (.clk(clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .reference_enable(reference_enable),
		.reference_ready(reference_ready), .temp_sense_enable(temp_sense_enable),
		.temp_range_select(temp_range_select),
		.converter_reference_gain(converter_reference_gain), .irq(irq));
	// standard variant shares the bus; only its ready pin is watched
	fixed_reference_temp_control #(.SETTLE_COUNT(SC), .STANDARD_VARIANT(1'b1)) dut_std (
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(), .reference_enable(),
		.reference_ready(std_ready), .temp_sense_enable(), .temp_range_select(),
		.converter_reference_gain(), .irq());

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wrap_up();
		repeat (3) @(posedge clk);
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		reg_read <= 1'b0;
	endtask

	// control pins laid out like the control word
	task automatic pin(input logic [7:0] e);
		@(negedge clk);
		chk({reference_enable, reference_ready, temp_sense_enable, temp_range_select,
			2'b00, converter_reference_gain}, e);
	endtask

	// counts edges from the write's taking edge until ready reaches lvl
	task automatic wait_ready(input logic lvl, output int n);
		n = 0;
		@(negedge clk);
		while (reference_ready !== lvl && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 50)
		begin
			bad_count++;
			wrap_up();
		end
	endtask

	// ------------------------------------------------------------
	// read data monitor
	// ------------------------------------------------------------
	always @(posedge clk)
		rd_d <= reg_read;

	always @(negedge clk)
		if (rd_d)
		begin
			if (exp_q.size() == 0)
				chk(8'hee, reg_rdata);
			else
				chk(reg_rdata, exp_q.pop_front());
		end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin : main
		int n;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		pin(8'h00);
		chk({7'h0, std_ready}, 8'h01);
		for (int a = 0; a < 16; a++)
			rd(a[3:0], 8'h00);
		for (int g = 0; g < 4; g++)
		begin
			wr(ADDR_CONTROL, 8'(g));
			pin(8'(g));
		end
		repeat (6)
		begin
			seed = lfsr(seed);
			d = seed[7:0] & 8'h7f;
			wr(ADDR_CONTROL, d | 8'h40);
			pin(d & 8'h33);
			rd(ADDR_CONTROL, d & 8'h33);
		end
		wr(ADDR_IRQ_ENABLE, 8'h03);
		rd(ADDR_IRQ_ENABLE, 8'h03);
		wr(ADDR_CONTROL, 8'h80);
		chk({7'h0, reference_ready}, 8'h00);
		wait_ready(1'b1, n);
		chk(8'(n), 8'(SC + 1));
		chk({7'h0, irq}, 8'h01);
		rd(ADDR_CONTROL, 8'hc0);
		wr(ADDR_IRQ_STATUS, 8'h00);
		rd(ADDR_IRQ_STATUS, 8'h01);
		wr(ADDR_IRQ_CLEAR, 8'h01);
		rd(ADDR_IRQ_STATUS, 8'h00);
		chk({7'h0, irq}, 8'h00);
		wr(ADDR_IRQ_ENABLE, 8'h02);
		wr(ADDR_CONTROL, 8'h00);
		wait_ready(1'b0, n);
		chk(8'(n), 8'h00);
		chk({6'h00, irq, std_ready}, 8'h03);
		rd(ADDR_IRQ_STATUS, 8'h02);
		wr(ADDR_IRQ_CLEAR, 8'h02);
		// enable dropped mid-settle must restart the count
		wr(ADDR_CONTROL, 8'h80);
		repeat (4) @(posedge clk);
		// off and on again in back-to-back write cycles
		@(posedge clk);
		reg_addr <= ADDR_CONTROL;
		reg_wdata <= 8'h00;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_wdata <= 8'h80;
		@(posedge clk);
		reg_write <= 1'b0;
		wait_ready(1'b1, n);
		chk(8'(n), 8'(SC + 1));
		chk({7'h0, irq}, 8'h00);
		rd(ADDR_IRQ_STATUS, 8'h01);
		wr(ADDR_CONTROL, 8'hb3);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		pin(8'h00);
		rd(ADDR_CONTROL, 8'h00);
		rd(ADDR_IRQ_STATUS, 8'h00);
		rd(ADDR_IRQ_ENABLE, 8'h00);
		wrap_up();
	end
endmodule
